/* design/irq_dma_routing_pkg.sv */
// Shared constants, types and per-device tables for the routing gate.
// Assumes one system clock; all users import the whole package.
package irq_dma_routing_pkg;

  // Logical device numbers
  localparam int NUM_LDN  = 11;        // Devices handled by the gate
  localparam int LDN_FDC  = 0;         // Floppy controller
  localparam int LDN_IDE1 = 1;         // First disk channel
  localparam int LDN_IDE2 = 2;         // Second disk channel
  localparam int LDN_PAR  = 3;         // Parallel port
  localparam int LDN_SER1 = 4;         // First serial port
  localparam int LDN_SER2 = 5;         // Second serial port
  localparam int LDN_RTC  = 6;         // Real time clock
  localparam int LDN_KBD  = 7;         // Keyboard controller
  localparam int LDN_AUX  = 8;         // Game port and address logic
  localparam int LDN_TWB  = 9;         // Two-wire host bus block
  localparam int LDN_ACPI = 10;        // Power management block

  // Configuration register indices
  localparam logic [7:0] IDX_ACTIVATE = 8'h30; // Activate bit 0
  localparam logic [7:0] IDX_BASE_HI  = 8'h60; // Primary base high
  localparam logic [7:0] IDX_BASE_LO  = 8'h61; // Primary base low
  localparam logic [7:0] IDX_BASE2_HI = 8'h62; // Secondary base high
  localparam logic [7:0] IDX_BASE2_LO = 8'h63; // Secondary base low
  localparam logic [7:0] IDX_IRQ_SEL  = 8'h70; // Interrupt level select
  localparam logic [7:0] IDX_DMA_SEL  = 8'h74; // DMA channel select

  // Reset values and codes
  localparam logic [3:0] IRQ_SEL_RESET  = 4'h0; // No interrupt
  localparam logic [2:0] DMA_SEL_RESET  = 3'h4; // No channel
  localparam logic [3:0] IRQ_CODE_NONE  = 4'h0; // Selects nothing
  localparam logic [3:0] IRQ_CODE_RSVD  = 4'h2; // Reserved level
  localparam logic [3:0] IRQ_CODE_SCI   = 4'hD; // Power block only
  localparam logic [2:0] DMA_CHAN_LAST  = 3'h3; // Highest channel
  localparam int         NUM_IRQ        = 16;   // Host interrupt lines
  localparam int         NUM_DMA        = 4;    // Host DMA channels

  // Address decode
  localparam logic [15:0] CMP_LEGACY = 16'h0FFF; // Twelve low bits
  localparam logic [15:0] CMP_FULL   = 16'hFFFF; // Power block bits
  localparam logic [15:0] ACPI2_IGN  = 16'h0007; // Eight byte block

  // Power block primary offsets
  localparam logic [3:0] PM_STS   = 4'h0; // Status pair
  localparam logic [3:0] PM_EN    = 4'h2; // Enable pair
  localparam logic [3:0] PM_CNT   = 4'h4; // Control pair
  localparam logic [3:0] PM_RSV_A = 4'h6; // Reserved
  localparam logic [3:0] PM_RSV_B = 4'h7; // Reserved
  localparam logic [3:0] PM_TMR   = 4'h8; // Timer bytes start
  localparam logic [3:0] PM_LAST  = 4'hB; // Timer bytes end
  // Power block secondary offsets
  localparam logic [2:0] SCI_STS  = 3'h0; // Control status pair
  localparam logic [2:0] SCI_EN   = 3'h2; // Control enable pair
  localparam logic [2:0] MSC_STS  = 3'h4; // Misc status
  localparam logic [2:0] SCI_RSV  = 3'h5; // Reserved
  localparam logic [2:0] MSC_EN   = 3'h6; // Misc enable
  localparam logic [2:0] SCI_RSV7 = 3'h7; // Unlisted
  // Two-wire block offsets
  localparam logic [1:0] TWB_CSR  = 2'h0; // Control and status
  localparam logic [1:0] TWB_OWN  = 2'h1; // Own address
  localparam logic [1:0] TWB_DATA = 2'h2; // Data
  localparam logic [1:0] TWB_CLK  = 2'h3; // Clock

  // Parallel extended control modes with interrupt forced on
  localparam logic [2:0] ECR_FIFO = 3'b010; // Fifo mode
  localparam logic [2:0] ECR_ECP  = 3'b011; // Extended mode
  localparam logic [2:0] ECR_TEST = 3'b110; // Test mode

  // Per-device decode tables, index is the device number
  localparam logic [15:0] IGN_MASK [NUM_LDN] = '{16'h0007, 16'h0007,
    16'h0007, 16'h0007, 16'h0007, 16'h0007, 16'h0001, 16'h0004,
    16'h0000, 16'h0003, 16'h000F};
  localparam logic [15:0] MIN_BASE [NUM_LDN] = '{16'h0100, 16'h0100,
    16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] FIX_BASE [NUM_LDN] = '{16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0070, 16'h0060,
    16'h0000, 16'h0000, 16'h0000};
  localparam logic [10:0] FIXED_LDN = 11'h0C0; // Clock and keyboard

  // Parallel port operating mode
  typedef enum logic [1:0] {
    PAR_SPP = 2'b00,                    // Standard
    PAR_EPP = 2'b01,                    // Enhanced
    PAR_ECP = 2'b10                     // Extended capability
  } par_mode_t;

  // Configuration access request
  typedef struct packed {
    logic       wr;                     // Write strobe
    logic       rd;                     // Read strobe
    logic [3:0] ldn;                    // Selected device
    logic [7:0] index;                  // Register index
    logic [7:0] wdata;                  // Write data
  } cfg_req_t;

  // Floppy block gating bits
  typedef struct packed {
    logic floppy_dma_gate;              // Gate bit of output control
    logic powerdown;                    // Controller powered down
  } fdc_ctrl_t;

  // Parallel block gating bits
  typedef struct packed {
    par_mode_t  mode;                   // Operating mode
    logic       parallel_irq_enable;    // Control port enable
    logic [2:0] ecr_mode;               // Extended control mode
    logic       parallel_service_interrupt; // Service bit
    logic       parallel_dma_enable;    // DMA enable bit
  } par_ctrl_t;

  // Serial block gating bits
  typedef struct packed {
    logic [3:0] serial_interrupt_enable; // Low enable bits
    logic       serial_user_output_two;  // Modem control out two
  } ser_ctrl_t;

endpackage

/* design/irq_dma_addr_match.sv */
// Base address comparator for one logical device block.
// Assumes the base is held stable by configuration logic.
module irq_dma_addr_match #(
  parameter logic [15:0] IGNORE  = 16'h0007, // Offset bits
  parameter logic [15:0] CMP     = 16'h0FFF, // Compared bits
  parameter logic [15:0] MINBASE = 16'h0100  // Lowest legal base
) (
  input  wire logic [15:0] i_addr,   // Host address
  input  wire logic [15:0] i_base,   // Programmed base
  input  wire logic        i_enable, // Cycle qualifier
  output logic             o_valid,  // Base is legal
  output logic             o_match   // Address in block
);

  logic [15:0] diff;                 // Differing address bits

  // Legal base: above the floor and aligned to the block
  always_comb begin
    o_valid = ((i_base & CMP) >= MINBASE) && ((i_base & IGNORE) == 16'h0000);
  end

  // Only the compared bits above the block offset count
  always_comb begin
    diff    = (i_addr ^ i_base) & CMP & ~IGNORE;
    o_match = i_enable && o_valid && (diff == 16'h0000);
  end

endmodule // irq_dma_addr_match

/* design/irq_dma_routing_gate.sv */
// Interrupt and DMA routing gate with block address decoding.
// Assumes synchronous host signals on the one system clock.
//
// Notes on behaviour
// - Level select low nibble picks line; zero none
// - Codes map to lines; 2 reserved, 13 power only
// - Lines active high, parallel enhanced and extended modes excepted
// - Interrupt needs nonzero level and device enable
// - Floppy needs gate bit and power up
// - Parallel standard modes need control enable
// - Extended mode also needs service bit clear
// - Extended mode DMA request needs DMA enable
// - Modes 010/011/110 force interrupt on
// - Serial needs enable bit and out two
// - Serial out two low floats its interrupt
// - Unselected interrupt pins float
// - Channel select low three bits, reset four
// - Channel active for codes 0-3 with enable
// - Unselected DMA request pins float
// - Block disables add to activate and base
// - Base decode uses twelve low address bits, power block all sixteen
// - Power block sixteen byte aligned layout
// - Power secondary block eight byte layout
// - Soft reset clears activate bits, leaves other registers alone
module irq_dma_routing_gate
  import irq_dma_routing_pkg::*;
(
  input  wire logic                  i_clk_sys,     // System clock
  input  wire logic                  i_rst_n,       // Hard reset, low
  input  wire logic                  i_soft_rst,    // Soft reset pulse
  input  wire irq_dma_routing_pkg::cfg_req_t i_cfg, // Config access
  output logic [7:0]                 o_cfg_rdata,   // Config read data
  input  wire logic [15:0]           i_io_addr,     // Host address
  input  wire logic                  i_io_aen,      // DMA owns bus, high
  output logic [10:0]                o_dev_sel,     // Primary block hit
  output logic                       o_acpi2_sel,   // Power second hit
  output logic [3:0]                 o_io_offset,   // Low four address bits
  input  wire logic [10:0]           i_dev_irq,     // Raw device irqs
  input  wire logic                  i_fdc_drq,     // Floppy request
  input  wire logic                  i_parallel_dma_request, // Par req
  input  wire irq_dma_routing_pkg::fdc_ctrl_t i_fdc, // Floppy gating
  input  wire irq_dma_routing_pkg::par_ctrl_t i_par, // Parallel gating
  input  wire irq_dma_routing_pkg::ser_ctrl_t i_ser1, // Serial 1 gating
  input  wire irq_dma_routing_pkg::ser_ctrl_t i_ser2, // Serial 2 gating
  input  wire logic [3:0]            i_dack_n,      // Host acks, low
  output logic [15:0]                o_irq_pin,     // Interrupt levels
  output logic [15:0]                o_irq_oe,      // Interrupt drive
  output logic [3:0]                 o_dma_request_pin, // DMA requests
  output logic [3:0]                 o_dma_request_oe,  // Request drive
  output logic                       o_fdc_dack_n,  // Floppy ack, low
  output logic                       o_par_dack_n   // Parallel ack, low
);

  // Configuration state per device
  logic [NUM_LDN-1:0] act;             // Activate bits
  logic [15:0]        base [NUM_LDN];  // Primary bases
  logic [3:0]         irq_sel [NUM_LDN]; // Level selects
  logic [2:0]         dma_sel [NUM_LDN]; // Channel selects
  logic [15:0]        acpi_base2;      // Power secondary base

  // Decode results
  logic [NUM_LDN-1:0] base_ok;         // Base legal per device
  logic [NUM_LDN-1:0] raw_hit;         // Address in block
  logic               acpi2_ok;        // Secondary base legal
  logic               acpi2_raw;       // Address in secondary
  logic [NUM_LDN-1:0] next_sel;        // Qualified hits
  logic               next_sel2;       // Qualified secondary hit

  // Routing results
  logic [NUM_LDN-1:0] irq_en;          // Device drives its line
  logic [NUM_LDN-1:0] irq_val;         // Level it drives
  logic [15:0]        next_irq_oe;     // Pin drive enables
  logic [15:0]        next_irq_pin;    // Pin levels
  logic               fdc_dma_on;      // Floppy channel live
  logic               par_dma_on;      // Parallel channel live
  logic [3:0]         next_drq_oe;     // Request drive enables
  logic [3:0]         next_drq_pin;    // Request levels
  logic               par_irq_ok;      // Parallel enable result
  logic               par_low;         // Parallel active low mode

  // Configuration writes; hard reset restores all defaults, soft reset only activate
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      act        <= '0;
      acpi_base2 <= 16'h0000;
      for (int i = 0; i < NUM_LDN; i++) begin
        base[i]    <= 16'h0000;
        irq_sel[i] <= IRQ_SEL_RESET;
        dma_sel[i] <= DMA_SEL_RESET;
      end
    end else if (i_soft_rst) begin
      // Soft reset only drops activation, selects stay        
      act <= '0;
    end else if (i_cfg.wr) begin
      for (int i = 0; i < NUM_LDN; i++) begin
        if (i_cfg.ldn == 4'(i)) begin
          case (i_cfg.index)
            IDX_ACTIVATE: act[i] <= i_cfg.wdata[0];
            IDX_BASE_HI:  base[i][15:8] <= i_cfg.wdata;
            IDX_BASE_LO:  base[i][7:0]  <= i_cfg.wdata;
            IDX_IRQ_SEL:  irq_sel[i] <= i_cfg.wdata[3:0];
            IDX_DMA_SEL:  dma_sel[i] <= i_cfg.wdata[2:0];
            default: ;                   // Other indices ignored
          endcase
        end
      end
      // Secondary base exists only for the power block
      if (i_cfg.ldn == 4'(LDN_ACPI)) begin
        if (i_cfg.index == IDX_BASE2_HI) begin
          acpi_base2[15:8] <= i_cfg.wdata;
        end else if (i_cfg.index == IDX_BASE2_LO) begin
          acpi_base2[7:0] <= i_cfg.wdata;
        end
      end
    end
  end

  // Configuration reads, registered, reserved bits zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= 8'h00;
    end else if (i_cfg.rd) begin
      o_cfg_rdata <= 8'h00;
      for (int i = 0; i < NUM_LDN; i++) begin
        if (i_cfg.ldn == 4'(i)) begin
          if (i_cfg.index == IDX_ACTIVATE) begin
            o_cfg_rdata <= {7'h00, act[i]};
          end else if (i_cfg.index == IDX_BASE_HI) begin
            o_cfg_rdata <= base[i][15:8];
          end else if (i_cfg.index == IDX_BASE_LO) begin
            o_cfg_rdata <= base[i][7:0];
          end else if (i_cfg.index == IDX_IRQ_SEL) begin
            o_cfg_rdata <= {4'h0, irq_sel[i]};
          end else if (i_cfg.index == IDX_DMA_SEL) begin
            o_cfg_rdata <= {5'h00, dma_sel[i]};
          end else if (i == LDN_ACPI && i_cfg.index == IDX_BASE2_HI) begin
            o_cfg_rdata <= acpi_base2[15:8];
          end else if (i == LDN_ACPI && i_cfg.index == IDX_BASE2_LO) begin
            o_cfg_rdata <= acpi_base2[7:0];
          end
        end
      end
    end
  end

  // One comparator per device block
  generate
    for (genvar g = 0; g < NUM_LDN; g++) begin : g_dec
      irq_dma_addr_match #(
        .IGNORE  (IGN_MASK[g]),
        .CMP     ((g == LDN_ACPI) ? CMP_FULL : CMP_LEGACY),
        .MINBASE (MIN_BASE[g])
      ) u_match (
        .i_addr   (i_io_addr),
        .i_base   (FIXED_LDN[g] ? FIX_BASE[g] : base[g]),
        .i_enable (act[g] && !i_io_aen),
        .o_valid  (base_ok[g]),
        .o_match  (raw_hit[g])
      );
    end
  endgenerate

  // Power block secondary comparator
  irq_dma_addr_match #(
    .IGNORE  (ACPI2_IGN),
    .CMP     (CMP_FULL),
    .MINBASE (16'h0000)
  ) u_acpi2 (
    .i_addr   (i_io_addr),
    .i_base   (acpi_base2),
    .i_enable (act[LDN_ACPI] && !i_io_aen),
    .o_valid  (acpi2_ok),
    .o_match  (acpi2_raw)
  );

  // Strip reserved holes from the power blocks; the two-wire block has none
  always_comb begin
    next_sel = raw_hit;
    // Two-wire block: four registers at offsets zero to three
    next_sel[LDN_TWB] = raw_hit[LDN_TWB] &&
      (i_io_addr[1:0] inside {TWB_CSR, TWB_OWN,
      TWB_DATA, TWB_CLK});
    // Primary power block: pairs, two reserved, four timer bytes
    next_sel[LDN_ACPI] = raw_hit[LDN_ACPI] &&
      (i_io_addr[3:0] <= PM_LAST) &&
      (i_io_addr[3:0] != PM_RSV_A) &&
      (i_io_addr[3:0] != PM_RSV_B);
    // Secondary power block: six byte offsets, holes at 5 and 7
    next_sel2 = acpi2_raw &&
      acpi2_ok &&
      (i_io_addr[2:0] != SCI_RSV) &&
      (i_io_addr[2:0] != SCI_RSV7);
  end

  // Registered decode outputs
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_dev_sel   <= '0;
      o_acpi2_sel <= 1'b0;
      o_io_offset <= 4'h0;
    end else begin
      o_dev_sel   <= next_sel;
      o_acpi2_sel <= next_sel2;
      // Raw address bits, not in-block
      o_io_offset <= i_io_addr[3:0];
    end
  end

  // Parallel interrupt enable by mode
  always_comb begin
    par_low    = (i_par.mode != PAR_SPP);
    par_irq_ok = i_par.parallel_irq_enable;
    if (i_par.mode == PAR_ECP) begin
      // Some extended modes force the enable on
      if (i_par.ecr_mode inside {ECR_FIFO, ECR_ECP, ECR_TEST}) begin
        par_irq_ok = 1'b1;
      end
      // Service bit must be clear as well
      par_irq_ok = par_irq_ok &&
        !i_par.parallel_service_interrupt;
    end
  end

  // Per-device interrupt gating
  always_comb begin
    for (int i = 0; i < NUM_LDN; i++) begin
      // Configuration level: active, legal base, usable code
      irq_en[i] = act[i] && base_ok[i] &&
                  (irq_sel[i] != IRQ_CODE_NONE) &&
                  (irq_sel[i] != IRQ_CODE_RSVD) &&
                  ((irq_sel[i] != IRQ_CODE_SCI) ||
                   (i == LDN_ACPI));
      irq_val[i] = i_dev_irq[i];
      case (i)
        LDN_FDC: begin
          // Floppy needs its gate bit and power
          irq_en[i] = irq_en[i] && i_fdc.floppy_dma_gate &&
                      !i_fdc.powerdown;
        end
        LDN_PAR: begin
          irq_en[i]  = irq_en[i] && par_irq_ok;
          irq_val[i] = par_low ? !i_dev_irq[i] :
            i_dev_irq[i];
        end
        LDN_SER1: begin
          irq_en[i] = irq_en[i] && (|i_ser1.serial_interrupt_enable) &&
                      i_ser1.serial_user_output_two;
        end
        LDN_SER2: begin
          irq_en[i] = irq_en[i] && (|i_ser2.serial_interrupt_enable) &&
                      i_ser2.serial_user_output_two;
        end
        LDN_AUX: begin
          irq_en[i] = 1'b0;
        end
        default: begin
          irq_en[i] = irq_en[i];
        end
      endcase
    end
  end

  // One driver check per host interrupt line
  generate
    for (genvar n = 0; n < NUM_IRQ; n++) begin : g_irq
      always_comb begin
        next_irq_oe[n]  = 1'b0;
        next_irq_pin[n] = 1'b0;
        // Any owner may raise it
        for (int i = 0; i < NUM_LDN; i++) begin
          if (irq_en[i] && (irq_sel[i] == 4'(n))) begin
            next_irq_oe[n]  = 1'b1;
            next_irq_pin[n] = next_irq_pin[n] | irq_val[i];
          end
        end
      end
    end
  endgenerate

  // Interrupt pins, floating when nobody owns them
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_irq_oe  <= 16'h0000;
      o_irq_pin <= 16'h0000;
    end else begin
      o_irq_oe  <= next_irq_oe;
      o_irq_pin <= next_irq_pin;
    end
  end

  // DMA channel ownership for the two users
  always_comb begin
    fdc_dma_on = act[LDN_FDC] && base_ok[LDN_FDC] &&
                 (dma_sel[LDN_FDC] <= DMA_CHAN_LAST) &&
                 i_fdc.floppy_dma_gate && !i_fdc.powerdown;
    par_dma_on = act[LDN_PAR] && base_ok[LDN_PAR] &&
                 (dma_sel[LDN_PAR] <= DMA_CHAN_LAST) &&
                 i_par.parallel_dma_enable;
  end

  // One driver check per host DMA channel
  generate
    for (genvar c = 0; c < NUM_DMA; c++) begin : g_dma
      always_comb begin
        next_drq_oe[c]  = 1'b0;
        next_drq_pin[c] = 1'b0;
        // Floppy request is ignored unless its gate is open
        if (fdc_dma_on && (dma_sel[LDN_FDC] == 3'(c))) begin
          next_drq_oe[c]  = 1'b1;
          next_drq_pin[c] = i_fdc_drq;
        end
        // Parallel request follows its enable in every mode
        if (par_dma_on && (dma_sel[LDN_PAR] == 3'(c))) begin
          next_drq_oe[c]  = 1'b1;
          next_drq_pin[c] = next_drq_pin[c] | i_parallel_dma_request;
        end
      end
    end
  endgenerate

  // DMA request pins and gated acknowledges
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_dma_request_oe  <= 4'h0;
      o_dma_request_pin <= 4'h0;
      o_fdc_dack_n      <= 1'b1;
      o_par_dack_n      <= 1'b1;
    end else begin
      o_dma_request_oe  <= next_drq_oe;
      o_dma_request_pin <= next_drq_pin;
      // Acknowledge passes only to the live owner
      // Live owner means select 0-3
      o_fdc_dack_n <= !(fdc_dma_on &&
                        !i_dack_n[dma_sel[LDN_FDC][1:0]]);
      o_par_dack_n <= !(par_dma_on &&
                        !i_dack_n[dma_sel[LDN_PAR][1:0]]);
    end
  end

endmodule // irq_dma_routing_gate

/* dv/irq_dma_routing_gate_props.sv */
// Port checker for the routing gate: reset, gating, decode.
// Bound to every gate instance; sees only its ports.
module irq_dma_routing_gate_props
  import irq_dma_routing_pkg::*;
(
  input wire logic        i_clk_sys,        // Clock
  input wire logic        i_rst_n,          // Reset, low
  input wire irq_dma_routing_pkg::cfg_req_t i_cfg, // Config
  input wire logic [7:0]  o_cfg_rdata,      // Read data
  input wire logic        i_io_aen,         // DMA cycle
  input wire logic [10:0] o_dev_sel,        // Block hits
  input wire logic        o_acpi2_sel,      // Second hit
  input wire irq_dma_routing_pkg::fdc_ctrl_t i_fdc, // Floppy
  input wire irq_dma_routing_pkg::par_ctrl_t i_par, // Parallel
  input wire logic [3:0]  i_dack_n,         // Host acks
  input wire logic [15:0] o_irq_oe,         // Irq drive
  input wire logic [3:0]  o_dma_request_oe, // Request drive
  input wire logic        o_fdc_dack_n,     // Floppy ack
  input wire logic        o_par_dack_n      // Parallel ack
);
  // One domain: shared clock and reset
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_irq_reset_idle: assert property (
    $rose(i_rst_n) |-> o_irq_oe == 16'h0000) else $error("irq driven");
  a_dma_reset_idle: assert property (
    $rose(i_rst_n) |-> o_dma_request_oe == 4'h0 && o_fdc_dack_n)
    else $error("request driven after reset");
  a_line_zero_two: assert property (
    o_irq_oe[0] == 1'b0 && o_irq_oe[2] == 1'b0)
    else $error("line zero or two driven");
  a_fdc_dack_gate: assert property (
    !o_fdc_dack_n |-> $past(i_fdc.floppy_dma_gate) &&
    !$past(i_fdc.powerdown)) else $error("floppy ack ungated");
  a_dack_host_ack: assert property (
    (!o_fdc_dack_n || !o_par_dack_n) |-> $past(i_dack_n) != 4'hF)
    else $error("ack without host ack");
  a_par_dack_en: assert property (
    !o_par_dack_n |-> $past(i_par.parallel_dma_enable))
    else $error("parallel ack without enable");
  a_aen_no_hit: assert property (
    i_io_aen |=> o_dev_sel == 11'h000 && !o_acpi2_sel)
    else $error("decode during DMA cycle");
  a_rdata_stands: assert property (
    !i_cfg.rd |=> $stable(o_cfg_rdata)) else $error("read data moved");
endmodule // irq_dma_routing_gate_props

bind irq_dma_routing_gate irq_dma_routing_gate_props chk_u (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
  .o_cfg_rdata(o_cfg_rdata), .i_io_aen(i_io_aen),
  .o_dev_sel(o_dev_sel), .o_acpi2_sel(o_acpi2_sel), .i_fdc(i_fdc),
  .i_par(i_par), .i_dack_n(i_dack_n), .o_irq_oe(o_irq_oe),
  .o_dma_request_oe(o_dma_request_oe),
  .o_fdc_dack_n(o_fdc_dack_n), .o_par_dack_n(o_par_dack_n));

/* dv/irq_dma_host_model.sv */
// Host DMA controller model: acknowledges driven, high requests.
// Assumes registered request pins and drive enables from the gate.
module irq_dma_host_model (
  input  wire logic       i_clk_sys, // Clock
  input  wire logic       i_ack_en,  // Grants allowed
  input  wire logic [3:0] i_req_pin, // Request levels
  input  wire logic [3:0] i_req_oe,  // Request drive
  output logic      [3:0] o_dack_n   // Acks, low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle acks until the first edge
  initial o_dack_n = 4'hF;
  // Floating request counts as idle
  always @(posedge i_clk_sys) begin
    o_dack_n <= ~(i_req_pin & i_req_oe & {4{i_ack_en}});
  end
endmodule // irq_dma_host_model

/* dv/testbench.sv */
// Self-checking bench for the irq and DMA routing gate.
// Assumes the host model and the bound port checker.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_dma_routing_pkg::*;
  logic        clk = 1'b0;  // System clock
  logic        rst_n = 1'b0; // Hard reset
  logic        srst = 1'b0;  // Soft reset
  logic        aen = 1'b0;  // DMA cycle
  logic        drq = 1'b0;  // Raw requests
  logic        ack = 1'b1;  // Host grants
  cfg_req_t    cfg = '0;    // Config access
  logic [15:0] addr = '0;   // Host address
  logic [10:0] dirq = '0;   // Raw irqs
  fdc_ctrl_t   fdc = '0;    // Floppy gating
  par_ctrl_t   par = '0;    // Parallel gating
  ser_ctrl_t   ser = '0;    // Serial gating
  logic [7:0]  rdata;       // Read data
  logic [10:0] sel;         // Block hits
  logic [3:0]  offs, dpin, doe, dack_n; // Offset, DMA side
  logic [15:0] ipin, ioe;   // Irq side
  logic        fdk_n, pdk_n; // Device acks
  int          mismatches = 0; // Failed compares
  int          cmp_count = 0;  // All compares

  irq_dma_routing_gate dut_u (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_soft_rst(srst), .i_cfg(cfg), .o_cfg_rdata(rdata),
    .i_io_addr(addr), .i_io_aen(aen), .o_dev_sel(sel),
    .o_acpi2_sel(), .o_io_offset(offs), .i_dev_irq(dirq),
    .i_fdc_drq(drq), .i_parallel_dma_request(drq), .i_fdc(fdc),
    .i_par(par), .i_ser1(ser), .i_ser2('0), .i_dack_n(dack_n),
    .o_irq_pin(ipin), .o_irq_oe(ioe), .o_dma_request_pin(dpin),
    .o_dma_request_oe(doe), .o_fdc_dack_n(fdk_n),
    .o_par_dack_n(pdk_n));
  irq_dma_host_model host_u (.i_clk_sys(clk), .i_ack_en(ack),
    .i_req_pin(dpin), .i_req_oe(doe), .o_dack_n(dack_n));

  // Clock, 20 ns period
  initial forever #10 clk = ~clk;

  task automatic check(string what, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One config strobe, write or read
  task automatic acc(logic [1:0] k, logic [3:0] l, logic [7:0] x,
                     logic [7:0] d);
    cfg = {k, l, x, d};
    tick(1);
    cfg = '0;
    tick(1);
  endtask
  // Activate device with base, irq code, channel
  task automatic up(logic [3:0] l, logic [15:0] b, logic [7:0] q,
                    logic [7:0] c);
    acc(2'b10, l, 8'h30, 8'h01);
    acc(2'b10, l, 8'h60, b[15:8]);
    acc(2'b10, l, 8'h61, b[7:0]);
    acc(2'b10, l, 8'h70, q);
    acc(2'b10, l, 8'h74, c);
    tick(2);
  endtask
  task automatic t_reset();
    acc(2'b01, 4'h0, 8'h70, 8'h00);
    check("irq select", rdata, 16'h0000);
    acc(2'b01, 4'h0, 8'h74, 8'h00);
    check("dma select", rdata, 16'h0004);
  endtask
  task automatic t_serial();
    up(4'h4, 16'h03F8, 8'h04, 8'h04);
    ser = '{4'h1, 1'b1};
    dirq[4] = 1'b1;
    for (int c = 0; c < 16; c++) begin
      acc(2'b10, 4'h4, 8'h70, 8'(c));
      tick(2);
      check("serial line", ioe, (c == 0 || c == 2 || c == 13) ?
            16'h0000 : 16'(1 << c));
    end
    acc(2'b10, 4'h4, 8'h70, 8'h04);
    ser.serial_user_output_two = 1'b0;
    tick(2);
    check("out two low", ioe, 16'h0000);
    ser = '{4'h0, 1'b1};
    tick(2);
    check("no enables", ioe, 16'h0000);
    ser = '{4'h8, 1'b1};
    tick(2);
    check("serial pin", ipin & ioe, 16'h0010);
    addr = 16'h13FA;
    tick(2);
    check("decode hit", {offs, 1'b0, sel}, 16'hA010);
    aen = 1'b1;
    tick(2);
    check("dma cycle", 16'(sel), 16'h0000);
    aen = 1'b0;
  endtask
  task automatic t_floppy();
    up(4'h0, 16'h03F0, 8'h06, 8'h02);
    fdc.floppy_dma_gate = 1'b1;
    drq = 1'b1;
    dirq[0] = 1'b1;
    tick(4);
    check("floppy drq", {dpin & doe, doe, 7'h0, fdk_n}, 16'h4400);
    check("floppy irq", ioe, 16'h0050);
    fdc.powerdown = 1'b1;
    tick(4);
    check("floppy off", {doe, ioe[11:0]}, 16'h0010);
    check("floppy ack", 16'(fdk_n), 16'h0001);
    fdc.powerdown = 1'b0;
    acc(2'b10, 4'h0, 8'h74, 8'h05);
    tick(2);
    check("no channel", 16'(doe), 16'h0000);
    acc(2'b10, 4'h0, 8'h74, 8'h02);
    acc(2'b10, 4'h0, 8'h30, 8'h00);
    tick(2);
    check("inactive", {doe, ioe[11:0]}, 16'h0010);
  endtask
  task automatic t_parallel();
    up(4'h3, 16'h0378, 8'h07, 8'h01);
    dirq[3] = 1'b1;
    for (int m = 0; m < 8; m++) begin
      par = '{PAR_ECP, 1'b0, 3'(m), 1'b0, 1'b0};
      tick(2);
      check("ecr mode", ioe, (m == 2 || m == 3 || m == 6) ?
            16'h0090 : 16'h0010);
    end
    par = '{PAR_ECP, 1'b0, ECR_FIFO, 1'b1, 1'b0};
    tick(2);
    check("service set", ioe, 16'h0010);
    par = '{PAR_SPP, 1'b0, 3'h0, 1'b0, 1'b1};
    tick(2);
    check("spp disabled", ioe, 16'h0010);
    check("par drq", 16'(doe), 16'h0002);
    tick(1);
    check("par ack", 16'(pdk_n), 16'h0000);
    par = '{PAR_SPP, 1'b1, 3'h0, 1'b0, 1'b0};
    tick(2);
    check("spp enabled", {doe, ioe[11:0]}, 16'h0090);
  endtask
  task automatic t_soft();
    srst = 1'b1;
    acc(2'b01, 4'h3, 8'h70, 8'h00);
    srst = 1'b0;
    check("soft reset", ioe, 16'h0000);
    check("select kept", 16'(rdata), 16'h0007);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(3);
    rst_n = 1'b1;
    t_reset();
    t_serial();
    t_floppy();
    t_parallel();
    t_soft();
    final_report();
  end
  // Hang guard, far past the expected run
  initial begin
    #200us;
    mismatches++;
    final_report();
  end
endmodule // testbench
